// ===== tdma_defines.svh
// Register map, field positions, reset values and sizes of the two-channel transfer engine.
// Assumes inclusion by bare name from the engine files.
`ifndef TDMA_DEFINES_SVH
`define TDMA_DEFINES_SVH

// ==========================================================
// Register offsets (channel block at 0x00, 0x20)
`define TDMA_CH_LIMIT 8'h40
`define TDMA_OFF_SRC 5'h00
`define TDMA_OFF_DST 5'h04
`define TDMA_OFF_CNT 5'h08
`define TDMA_OFF_CTRL 5'h0c
`define TDMA_OFF_START 5'h10
`define TDMA_OFF_STAT 5'h14
`define TDMA_REG_MODE 8'h40
`define TDMA_REG_INTSTAT 8'h44
`define TDMA_REG_INTMASK 8'h48

// ==========================================================
// Control and status field positions
`define TDMA_CTRL_SIZE_LO 0
`define TDMA_CTRL_BURST 2
`define TDMA_CTRL_EXTEN 3
`define TDMA_CTRL_SRCINC 4
`define TDMA_CTRL_DSTINC 5
`define TDMA_CTRL_W 6
`define TDMA_STAT_ACTIVE 31

// ==========================================================
// Reset values and sizes
`define TDMA_CTRL_RST 6'h30
`define TDMA_CNT_W 16
`define TDMA_CNT_FULL 17'h10000
`define TDMA_NCH 2

`endif

// ===== tdma_pkg.sv
// Types used by the transfer engine: sequencer states and unit sizes.
// Assumes nothing of its surroundings.
package tdma_pkg;

	// ==========================================================
	// Engine sequencer states, one-hot
	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_REQ = 5'b00010,
		S_RD = 5'b00100,
		S_WR = 5'b01000,
		S_NEXT = 5'b10000
	} tdma_state_t;

	// ==========================================================
	// Transfer unit
	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_HALF = 2'h1,
		SZ_WORD = 2'h2
	} tdma_size_t;

endpackage

// ===== tdma_arbiter.sv
// Two-way channel arbiter with fixed or round-robin priority.
// Assumes requests and the take strobe come from logic on mclk.
`timescale 1ns/1ps

module tdma_arbiter (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Requests and mode
	input wire logic [1:0] chanReq,
	input wire logic roundRobin,
	input wire logic take,
	// Result
	output logic grantValid,
	output logic grantChan
);

	logic lastChan_q;
	logic fixedPick;
	logic rrPick;

	// Fixed: channel 0 wins a tie; round-robin: last served loses a tie
	assign fixedPick = ~chanReq[0];
	assign rrPick = (&chanReq) ? ~lastChan_q : ~chanReq[0];
	assign grantValid = |chanReq;
	assign grantChan = roundRobin ? rrPick : fixedPick;

	// Remember the channel served most recently
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			lastChan_q <= 1'b1;
		end else if (take) begin
			lastChan_q <= grantChan;
		end
	end

endmodule

// ===== tdma_transfer_engine.sv
// Two-channel transfer engine: registers, request logic, bus sequencer, interrupts.
// Assumes one clock mclk, a bus arbiter answering busReq with busGrant, and a system bus
// that answers each read or write strobe with busReady (and busErr on a failed cycle).
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "tdma_defines.svh"

module tdma_transfer_engine #(
	parameter int AW = 32,
	parameter int DW = 32
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	// External request pins
	input wire logic [1:0] dreq,
	// System bus requester
	output logic busReq,
	input wire logic busGrant,
	output logic [AW-1:0] busAddr,
	output logic busRd,
	output logic busWr,
	output logic [1:0] busSize,
	output logic [DW-1:0] busWdata,
	input wire logic [DW-1:0] busRdata,
	input wire logic busReady,
	input wire logic busErr,
	// Interrupts, one per channel
	output logic [1:0] irq
);

	// ==========================================================
	// Address step for a unit size
	function automatic logic [AW-1:0] stepOf(input logic [1:0] size);
		logic [AW-1:0] s;
		s = AW'(1);
		if (size == tdma_pkg::SZ_HALF) begin
			s = AW'(2);
		end else if (size == tdma_pkg::SZ_WORD) begin
			s = AW'(4);
		end
		return s;
	endfunction

	// ==========================================================
	// State
	logic [AW-1:0] src_q [2];
	logic [AW-1:0] dst_q [2];
	logic [`TDMA_CNT_W-1:0] cnt_q [2];
	logic [`TDMA_CTRL_W-1:0] ctrl_q [2];
	logic [16:0] rem_q [2];
	logic [1:0] active_q;
	logic roundRobin_q;
	logic [3:0] intStat_q;
	logic [1:0] intMask_q;
	logic [1:0] evDone_q;
	logic [1:0] evErr_q;
	logic [1:0] dreqMeta_q;
	logic [1:0] dreqSync_q;
	logic [1:0] dreqPrev_q;
	logic [31:0] regRdata_q;
	logic [1:0] irq_q;
	logic busReq_q;
	logic [AW-1:0] busAddr_q;
	logic busRd_q;
	logic busWr_q;
	logic [1:0] busSize_q;
	logic [DW-1:0] busWdata_q;
	logic curChan_q;
	tdma_pkg::tdma_state_t state_q;

	// ==========================================================
	// Register decode
	logic chanSpace;
	logic wrChan;
	logic [4:0] chOff;
	logic [1:0] startReq;
	logic [1:0] extStart;
	logic [1:0] startAny;
	logic [31:0] chanRdata;
	logic [31:0] rdMux;
	logic [3:0] intClr;

	// Channel block select and offset
	assign chanSpace = regAddr < `TDMA_CH_LIMIT;
	assign wrChan = regAddr[5];
	assign chOff = regAddr[4:0];
	assign intClr = (regWr && regAddr == `TDMA_REG_INTSTAT) ? regWdata[3:0] : 4'h0;

	// Start sources: software bit or rising edge of an enabled request pin
	genvar gc;
	generate
		for (gc = 0; gc < `TDMA_NCH; gc++) begin : gStart
			assign startReq[gc] = regWr && chanSpace && (wrChan == 1'(gc)) &&
				(chOff == `TDMA_OFF_START) && regWdata[0];
			assign extStart[gc] = ctrl_q[gc][`TDMA_CTRL_EXTEN] &&
				dreqSync_q[gc] && !dreqPrev_q[gc];
			assign startAny[gc] = (startReq[gc] || extStart[gc]) && !active_q[gc];
		end
	endgenerate

	// Channel register read selection
	always_comb begin
		chanRdata = 32'h0;
		unique case (chOff)
			`TDMA_OFF_SRC: chanRdata = 32'(src_q[wrChan]);
			`TDMA_OFF_DST: chanRdata = 32'(dst_q[wrChan]);
			`TDMA_OFF_CNT: chanRdata = {16'h0, cnt_q[wrChan]};
			`TDMA_OFF_CTRL: chanRdata = {26'h0, ctrl_q[wrChan]};
			`TDMA_OFF_STAT: chanRdata = {active_q[wrChan], 14'h0, rem_q[wrChan]};
			default: chanRdata = 32'h0;
		endcase
	end

	// Global register read selection; unmapped reads return zero
	assign rdMux = chanSpace ? chanRdata :
		(regAddr == `TDMA_REG_MODE) ? {31'h0, roundRobin_q} :
		(regAddr == `TDMA_REG_INTSTAT) ? {28'h0, intStat_q} :
		(regAddr == `TDMA_REG_INTMASK) ? {30'h0, intMask_q} : 32'h0;

	// ==========================================================
	// Arbitration
	logic grantValid;
	logic grantChan;
	logic take;
	logic cur;
	logic [1:0] curSize;
	logic [1:0] ctrlSize;
	logic lastUnit;

	// Current channel, its unit and whether this is its final unit
	assign cur = curChan_q;
	assign ctrlSize = ctrl_q[cur][`TDMA_CTRL_SIZE_LO +: 2];
	// The spare size code runs as a byte, matching the address step and keeping busSize legal
	assign curSize = (ctrlSize == 2'h3) ? tdma_pkg::SZ_BYTE : ctrlSize;
	assign lastUnit = rem_q[cur] == 17'h1;
	assign take = (state_q == tdma_pkg::S_IDLE) && grantValid;

	// Arbiter picks among active channels; take marks each new pick
	tdma_arbiter uArb (
		.mclk(mclk),
		.resetn(resetn),
		.chanReq(active_q),
		.roundRobin(roundRobin_q),
		.take(take),
		.grantValid(grantValid),
		.grantChan(grantChan)
	);

	// ==========================================================
	// Request pin synchroniser and edge memory
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			dreqMeta_q <= 2'h0;
			dreqSync_q <= 2'h0;
			dreqPrev_q <= 2'h0;
		end else begin
			dreqMeta_q <= dreq;
			dreqSync_q <= dreqMeta_q;
			dreqPrev_q <= dreqSync_q;
		end
	end

	// ==========================================================
	// Channel registers: software writes, engine stepping
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			for (int c = 0; c < `TDMA_NCH; c++) begin
				src_q[c] <= '0;
				dst_q[c] <= '0;
				cnt_q[c] <= '0;
				ctrl_q[c] <= `TDMA_CTRL_RST;
				rem_q[c] <= 17'h0;
			end
			active_q <= 2'h0;
		end else begin
			for (int c = 0; c < `TDMA_NCH; c++) begin
				if (regWr && chanSpace && wrChan == 1'(c)) begin
					if (chOff == `TDMA_OFF_SRC) src_q[c] <= AW'(regWdata);
					if (chOff == `TDMA_OFF_DST) dst_q[c] <= AW'(regWdata);
					if (chOff == `TDMA_OFF_CNT) cnt_q[c] <= regWdata[15:0];
					if (chOff == `TDMA_OFF_CTRL) ctrl_q[c] <= regWdata[5:0];
				end
				if (startAny[c]) begin
					active_q[c] <= 1'b1;
					rem_q[c] <= (cnt_q[c] == '0) ? `TDMA_CNT_FULL : {1'b0, cnt_q[c]};
				end
			end
			if (state_q == tdma_pkg::S_WR && busReady) begin
				if (busErr) begin
					active_q[cur] <= 1'b0;
				end else begin
					// Memory sides step, I/O sides stay put
					if (ctrl_q[cur][`TDMA_CTRL_SRCINC]) src_q[cur] <= src_q[cur] + stepOf(curSize);
					if (ctrl_q[cur][`TDMA_CTRL_DSTINC]) dst_q[cur] <= dst_q[cur] + stepOf(curSize);
					rem_q[cur] <= rem_q[cur] - 17'h1;
					if (lastUnit) active_q[cur] <= 1'b0;
				end
			end else if (state_q == tdma_pkg::S_RD && busReady && busErr) begin
				active_q[cur] <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Bus sequencer
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q <= tdma_pkg::S_IDLE;
			curChan_q <= 1'b0;
			busReq_q <= 1'b0;
			busAddr_q <= '0;
			busRd_q <= 1'b0;
			busWr_q <= 1'b0;
			busSize_q <= 2'h0;
			busWdata_q <= '0;
			evDone_q <= 2'h0;
			evErr_q <= 2'h0;
		end else begin
			evDone_q <= 2'h0;
			evErr_q <= 2'h0;
			unique case (state_q)
				tdma_pkg::S_IDLE: begin
					if (grantValid) begin
						curChan_q <= grantChan;
						busReq_q <= 1'b1;
						state_q <= tdma_pkg::S_REQ;
					end
				end
				tdma_pkg::S_REQ: begin
					// Hold the request until the bus arbiter grants it
					if (busGrant) begin
						busAddr_q <= src_q[cur];
						busSize_q <= curSize;
						busRd_q <= 1'b1;
						state_q <= tdma_pkg::S_RD;
					end
				end
				tdma_pkg::S_RD: begin
					if (busReady && busErr) begin
						busRd_q <= 1'b0;
						busReq_q <= 1'b0;
						evErr_q[cur] <= 1'b1;
						state_q <= tdma_pkg::S_IDLE;
					end else if (busReady) begin
						busRd_q <= 1'b0;
						busWr_q <= 1'b1;
						busAddr_q <= dst_q[cur];
						busWdata_q <= busRdata;
						state_q <= tdma_pkg::S_WR;
					end
				end
				tdma_pkg::S_WR: begin
					if (busReady) begin
						busWr_q <= 1'b0;
						if (busErr) begin
							busReq_q <= 1'b0;
							evErr_q[cur] <= 1'b1;
							state_q <= tdma_pkg::S_IDLE;
						end else begin
							if (lastUnit) evDone_q[cur] <= 1'b1;
							state_q <= tdma_pkg::S_NEXT;
						end
					end
				end
				tdma_pkg::S_NEXT: begin
					if (ctrl_q[cur][`TDMA_CTRL_BURST] && active_q[cur]) begin
						// Burst keeps the bus until the count is exhausted
						busAddr_q <= src_q[cur];
						busRd_q <= 1'b1;
						state_q <= tdma_pkg::S_RD;
					end else begin
						busReq_q <= 1'b0;
						state_q <= tdma_pkg::S_IDLE;
					end
				end
				default: begin
					busReq_q <= 1'b0;
					busRd_q <= 1'b0;
					busWr_q <= 1'b0;
					state_q <= tdma_pkg::S_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Global registers, interrupt status and outputs
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			roundRobin_q <= 1'b0;
			intMask_q <= 2'h0;
			intStat_q <= 4'h0;
			regRdata_q <= 32'h0;
			irq_q <= 2'h0;
		end else begin
			// Mode and mask writes
			if (regWr && regAddr == `TDMA_REG_MODE) roundRobin_q <= regWdata[0];
			if (regWr && regAddr == `TDMA_REG_INTMASK) intMask_q <= regWdata[1:0];
			// A new event wins over a clear in the same cycle
			intStat_q <= (intStat_q & ~intClr) | {evErr_q, evDone_q};
			regRdata_q <= regRd ? rdMux : 32'h0;
			// Per-channel line: done or error, unless that channel is masked
			for (int c = 0; c < `TDMA_NCH; c++) begin
				irq_q[c] <= (intStat_q[c] | intStat_q[c+2]) & ~intMask_q[c];
			end
		end
	end

	assign regRdata = regRdata_q;
	assign busReq = busReq_q;
	assign busAddr = busAddr_q;
	assign busRd = busRd_q;
	assign busWr = busWr_q;
	assign busSize = busSize_q;
	assign busWdata = busWdata_q;
	assign irq = irq_q;

endmodule

// ===== tdma_bus_model.sv
// Bus arbiter and memory model facing the transfer engine.
// Assumes the engine holds each command until busReady.
`timescale 1ns/1ps

module tdma_bus_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Test controls
	input wire logic slow,
	input wire logic [31:0] errAddr,
	// Engine side
	input wire logic busReq,
	input wire logic [31:0] busAddr,
	input wire logic busRd,
	input wire logic busWr,
	output logic busGrant,
	output logic [31:0] busRdata,
	output logic busReady,
	output logic busErr
);
	logic [1:0] wait_q;
	// ==========================================================
	// Grant follows request; slow adds two wait cycles; data valid only with ready
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			busGrant <= 1'b0;
			busRdata <= 32'h0;
			busReady <= 1'b0;
			busErr <= 1'b0;
			wait_q <= 2'h0;
		end else begin
			busGrant <= busReq;
			busReady <= 1'b0;
			busErr <= 1'b0;
			busRdata <= ~busRdata; // Released data keeps toggling
			if ((busRd || busWr) && busGrant && !busReady) begin
				if (slow && wait_q < 2'h2) begin
					wait_q <= wait_q + 2'h1;
				end else begin
					wait_q <= 2'h0;
					busReady <= 1'b1;
					busErr <= busAddr == errAddr;
					busRdata <= {busAddr[15:0], ~busAddr[15:0]};
				end
			end
		end
	end
endmodule

// ===== tdma_engine_sva.sv
// Port checker of the transfer engine, bound into every engine instance.
// Assumes one clock mclk and the asynchronous active-low reset resetn.
`timescale 1ns/1ps

module tdma_engine_chk #(
	parameter int AW = 32,
	parameter int DW = 32
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [31:0] regRdata,
	// Bus and interrupts
	input wire logic busReq,
	input wire logic busGrant,
	input wire logic [AW-1:0] busAddr,
	input wire logic busRd,
	input wire logic busWr,
	input wire logic [1:0] busSize,
	input wire logic busReady,
	input wire logic busErr,
	input wire logic [1:0] irq
);
	logic cmd;
	logic startWr;
	// ==========================================================
	// Decodes shared by the properties
	assign cmd = busRd || busWr;
	assign startWr = regWr && regAddr < 8'h40 && regAddr[4:0] == 5'h10 && regWdata[0];
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	// ==========================================================
	// Properties
	a_cmd_held: assert property (cmd && !busReady |=> $stable({busRd, busWr, busAddr, busSize}))
		else $error("bus command changed before ready");
	a_one_cmd: assert property (!(busRd && busWr))
		else $error("read and write at once");
	a_size_legal: assert property (cmd |-> busSize != 2'h3)
		else $error("illegal unit size");
	a_cmd_needs_req: assert property (cmd |-> busReq)
		else $error("command without bus request");
	a_grant_first: assert property ($rose(busRd) |-> $past(busGrant))
		else $error("read before grant");
	a_read_write: assert property (busRd && busReady && !busErr |=> busWr)
		else $error("no write after read");
	a_err_stop: assert property (busReady && busErr |=> !busRd && !busWr)
		else $error("command kept after error");
	a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 32'h0)
		else $error("read data outside its cycle");
	a_mask_silence: assert property (regWr && regAddr == 8'h48 && regWdata[1:0] == 2'h3 |-> ##2 irq == 2'h0)
		else $error("masked interrupt raised");
	a_start_req: assert property (startWr && !busReq |-> ##2 busReq)
		else $error("start without bus request");
	c_error: cover property (busReady && busErr);
	c_irq1: cover property ($rose(irq[1]));
	c_write: cover property (busWr && busReady);
endmodule

bind tdma_transfer_engine tdma_engine_chk #(.AW(AW), .DW(DW)) tdma_engine_chk_inst (
	.mclk(mclk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
	.regRd(regRd), .regRdata(regRdata), .busReq(busReq), .busGrant(busGrant),
	.busAddr(busAddr), .busRd(busRd), .busWr(busWr), .busSize(busSize),
	.busReady(busReady), .busErr(busErr), .irq(irq)
);

// ===== tdma_tb.sv
// Self-checking bench of the transfer engine with a bus model.
// Assumes the engine, its checker and the bus model are compiled first.
`timescale 1ns/1ps

module tb;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] regAddr = 8'h0;
	logic [31:0] regWdata = 32'h0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [1:0] dreq = 2'h0;
	logic slow = 1'b0;
	logic [31:0] errAddr = 32'hffffffff;
	logic [31:0] regRdata, busAddr, busWdata, busRdata, lastRd, d;
	logic busReq, busGrant, busRd, busWr, busReady, busErr, prevReq;
	logic [1:0] busSize, irq, curSize;
	logic [31:0] rdQ[$], wrQ[$];
	logic [7:0] ctl [5] = '{8'h30, 8'h35, 8'h22, 8'h16, 8'h02};
	int failures = 0;
	int num_checks = 0;
	int reqFalls;

	tdma_transfer_engine tdma_transfer_engine_inst (.mclk(mclk), .resetn(resetn),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .dreq(dreq), .busReq(busReq), .busGrant(busGrant),
		.busAddr(busAddr), .busRd(busRd), .busWr(busWr), .busSize(busSize),
		.busWdata(busWdata), .busRdata(busRdata), .busReady(busReady), .busErr(busErr),
		.irq(irq));
	tdma_bus_model tdma_bus_model_inst (.mclk(mclk), .resetn(resetn), .slow(slow),
		.errAddr(errAddr), .busReq(busReq), .busAddr(busAddr), .busRd(busRd),
		.busWr(busWr), .busGrant(busGrant), .busRdata(busRdata), .busReady(busReady),
		.busErr(busErr));

	// ==========================================================
	// Clock, tasks and bus monitor
	always #25 mclk = ~mclk;

	task automatic results;
		if (failures == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		@(negedge mclk);
		d = regRdata;
		chk(d, e);
		@(posedge mclk);
	endtask

	task automatic waitDone(input logic [1:0] m);
		int n;
		n = 0;
		while ((irq & m) !== m && n < 4000) begin
			@(posedge mclk);
			n++;
		end
		if (n == 4000) begin
			failures++;
			$display("ERROR %0t: timeout", $time);
			results();
		end
	endtask

	task automatic resetDut;
		resetn <= 1'b0;
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
	endtask

	task automatic setup(input logic [7:0] b, input logic [31:0] s, input logic [31:0] n,
		input logic [7:0] c);
		wr(b, s);
		wr(b + 8'h4, s + 32'h100);
		wr(b + 8'h8, n);
		wr(b + 8'hc, {24'h0, c});
		rdQ.delete();
		wrQ.delete();
		reqFalls = 0;
		curSize = c[1:0];
	endtask

	// Logs error-free reads and all finished writes, checks copied data and unit, counts request drops
	always @(posedge mclk) begin
		if (busReady && busRd && !busErr) begin
			rdQ.push_back(busAddr);
			lastRd = busAddr;
		end
		if (busReady && busWr) begin
			wrQ.push_back(busAddr);
			chk(busWdata, {lastRd[15:0], ~lastRd[15:0]});
			chk({30'h0, busSize}, {30'h0, curSize});
		end
		if (prevReq && !busReq) reqFalls++;
		prevReq = busReq;
	end

	// ==========================================================
	// Test sequence
	initial begin
		resetDut();
		rdchk(8'h0c, 32'h30);
		rdchk(8'h2c, 32'h30);
		rdchk(8'h40, 32'h0);
		rdchk(8'h48, 32'h0);
		wr(8'h60, 32'hffffffff);
		rdchk(8'h60, 32'h0);
		for (int i = 0; i < 5; i++) begin
			setup(8'(32 * (i % 2)), 32'h100, (i == 4) ? 32'h1 : 32'h3, ctl[i]);
			slow <= i[0];
			wr(8'(32 * (i % 2) + 16), 32'h1);
			waitDone(2'(1 << (i % 2)));
			chk(32'(wrQ.size()), (i == 4) ? 32'h1 : 32'h3);
			for (int k = 0; k < wrQ.size(); k++) begin
				chk(rdQ[k], 32'h100 + (ctl[i][4] ? k << ctl[i][1:0] : 0));
				chk(wrQ[k], 32'h200 + (ctl[i][5] ? k << ctl[i][1:0] : 0));
			end
			rdchk(8'h44, 32'h1 << (i % 2));
			chk(32'(reqFalls), ctl[i][2] ? 32'h1 : 32'(wrQ.size()));
			chk({30'h0, irq}, 32'h1 << (i % 2));
			wr(8'h44, 32'hf);
			rdchk(8'h44, 32'h0);
		end
		slow <= 1'b0;
		for (int m = 0; m < 2; m++) begin
			resetDut();
			wr(8'h40, m);
			setup(8'h20, 32'h2000, 32'h2, 8'h38);
			setup(8'h00, 32'h1000, 32'h2, 8'h38);
			dreq <= 2'h3;
			repeat (4) @(posedge mclk);
			dreq <= 2'h0;
			waitDone(2'h3);
			for (int k = 0; k < 4; k++) begin
				chk({31'h0, rdQ[k][13]}, m ? k % 2 : k / 2);
			end
			rdchk(8'h44, 32'h3);
			wr(8'h44, 32'hf);
		end
		errAddr <= 32'h304;
		setup(8'h00, 32'h300, 32'h3, 8'h32);
		wr(8'h10, 32'h1);
		waitDone(2'h1);
		chk(32'(wrQ.size()), 32'h1);
		rdchk(8'h14, 32'h2);
		rdchk(8'h44, 32'h4);
		wr(8'h48, 32'h2);
		rdchk(8'h48, 32'h2);
		chk({30'h0, irq}, 32'h1);
		wr(8'h48, 32'h3);
		rdchk(8'h44, 32'h4);
		chk({30'h0, irq}, 32'h0);
		wr(8'h48, 32'h0);
		rdchk(8'h48, 32'h0);
		chk({30'h0, irq}, 32'h1);
		wr(8'h44, 32'h4);
		rdchk(8'h44, 32'h0);
		chk({30'h0, irq}, 32'h0);
		// Error in the write phase of the second unit on channel 1
		errAddr <= 32'h604;
		setup(8'h20, 32'h500, 32'h2, 8'h32);
		wr(8'h30, 32'h1);
		waitDone(2'h2);
		chk(32'(wrQ.size()), 32'h2);
		rdchk(8'h34, 32'h1);
		rdchk(8'h44, 32'h8);
		chk({30'h0, irq}, 32'h2);
		results();
	end
endmodule
